// File: src/fsqmc_map.svh
// Purpose: Offsets, field positions, reset values, opcodes and timing counts of the flash command block.
// Assumes: Included by bare name; definitions only.
// Notes: Opcodes are one byte; register offsets are byte addresses of 32-bit words.
`ifndef FSQMC_MAP_SVH
`define FSQMC_MAP_SVH
// ----------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------
`define FQ_OP_RD_FUNC 8'h48
`define FQ_OP_WR_FUNC 8'h42
`define FQ_OP_QUAD_ON 8'h35
`define FQ_OP_QUAD_OFF 8'hF5
`define FQ_OP_SUSP_A 8'h75
`define FQ_OP_SUSP_B 8'hB0
`define FQ_OP_RESUME_A 8'h7A
`define FQ_OP_RESUME_B 8'h30
`define FQ_OP_WR_STAT 8'h01
`define FQ_OP_RD_STAT 8'h05
`define FQ_OP_WR_EN 8'h06
`define FQ_OP_WR_DIS 8'h04
`define FQ_OP_READ 8'h03
`define FQ_OP_FAST 8'h0B
`define FQ_OP_DUAL_IO 8'hBB
`define FQ_OP_DUAL_OUT 8'h3B
`define FQ_OP_QUAD_IO 8'hEB
`define FQ_OP_QUAD_OUT 8'h6B
`define FQ_OP_PROG 8'h02
`define FQ_OP_PROG_Q_A 8'h32
`define FQ_OP_PROG_Q_B 8'h38
`define FQ_OP_SECT_A 8'h20
`define FQ_OP_SECT_B 8'hD7
`define FQ_OP_BLK32 8'h52
`define FQ_OP_BLK64 8'hD8
`define FQ_OP_CHIP_A 8'hC7
`define FQ_OP_CHIP_B 8'h60
`define FQ_OP_RST_EN 8'h66
`define FQ_OP_RST 8'h99
`define FQ_OP_ID_A 8'hAB
`define FQ_OP_ID_B 8'h9F
`define FQ_OP_ID_C 8'hAF
`define FQ_OP_ID_D 8'h90
`define FQ_OP_UID 8'h4B
`define FQ_OP_SFDP 8'h5A
`define FQ_OP_NOP 8'h00
`define FQ_OP_ROW_RD 8'h68
`define FQ_OP_SEC_UNL 8'h26
`define FQ_OP_SEC_LCK 8'h24
`define FQ_OP_WRAP 8'hC0
// ----------------------------------------------------------------
// Registers, fields, masks and reset values
// ----------------------------------------------------------------
`define FQ_REG_STAT 4'h0
`define FQ_REG_OPCTL 4'h4
`define FQ_REG_FUNC 4'h8
`define FQ_OPCTL_DONE 0
`define FQ_FUNC_PROGRAM_SUSPENDED_FLAG 2
`define FQ_FUNC_ERASE_SUSPENDED_FLAG 3
`define FQ_MASK_SECT 24'hFFF000
`define FQ_MASK_B32 24'hFF8000
`define FQ_MASK_B64 24'hFF0000
`define FQ_PIN_RST 6'h20
`define FQ_STAT_RST 6'h00
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define FQ_CLK_NS 40
`define FQ_TSUS_NS 100000
`define FQ_TSUS_CYC ((`FQ_TSUS_NS + `FQ_CLK_NS - 1) / `FQ_CLK_NS)
`endif

// File: src/fsqmc_pkg.sv
// Purpose: Types shared by the flash command block.
// Assumes: Nothing.
// Notes: One-hot codes are written out.
package fsqmc_pkg;
  // Frame phase of the serial link.
  typedef enum logic [4:0] {
    FR_IDLE = 5'h01,
    FR_CMD = 5'h02,
    FR_ARG = 5'h04,
    FR_OUT = 5'h08,
    FR_SKIP = 5'h10
  } fsqmc_frame_t;
  // Internally timed operation now running.
  typedef enum logic [3:0] {
    RUN_NONE = 4'h1,
    RUN_PROG = 4'h2,
    RUN_ERASE = 4'h4,
    RUN_CHIP = 4'h8
  } fsqmc_run_t;
endpackage

// File: src/fsqmc_top.sv
// Purpose: Command handling of a serial flash: function register, quad mode, suspend and resume.
// Assumes: Host uses clock mode 0; link pins are sampled by i_clock at 25 MHz.
// Notes: Array data paths stay outside; software reports end of a timed operation.
// Notes on behaviour
// - Opcode 48h returns the function register.
// - Opcode 42h sets row lock bits individually.
// - Row lock bits never return to zero.
// - Function write needs latch; latch then clears.
// - Opcode 35h switches all commands to quad.
// - F5h leaves quad, accepted only quad-format.
// - Suspend and resume work in both modes.
// - Program suspend bit2, erase suspend bit3.
// - Suspend sector/block erase; ignore during chip erase.
// - Erase suspend blocks erases, erased reads, not 01h.
// - Program suspend blocks programs, page reads, not 01h.
// - Erase suspend sets flag, busy until ready.
// - Program suspend sets flag, busy until ready.
// - Any suspend flag rising clears write latch.
// - Resume restarts operation, clears both flags.
// - Quad cycle is two nibbles, high first.
// - Array reads accepted during either suspend.
// - Page programs accepted only in erase suspend.
// - Erase suspend accepts a further suspend.
// - During suspend 01h acts as volatile write.
// - Suspended reset needs preceding reset enable.
// - Busy bit reads one while operation active.
`timescale 1ns/1ps
`include "fsqmc_map.svh"
module fsqmc_top import fsqmc_pkg::*; (
  // Clock, reset, enable
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_ce,
  // Link pins
  input wire logic i_csn_pin,
  input wire logic i_sck_pin,
  input wire logic [3:0] i_io_pin,
  output logic [3:0] o_io_out,
  output logic [3:0] o_io_oe,
  // Register port
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // Status
  output logic o_quad_mode,
  output logic o_write_in_progress,
  output logic o_read_grant
);
  // ----------------------------------------------------------------
  // Pin sampling
  // ----------------------------------------------------------------
  logic [5:0] sync1_q, sync2_q, sync3_q, pin_q; // Order: csn, sck, io[3:0].
  logic [5:0] pin_d; // Filtered pin level once two stages agree.
  logic sck_rise, sck_fall, cs_start, cs_end;

  // Three stages; a change counts once the last two agree, which rejects a single metastable sample.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      sync1_q <= `FQ_PIN_RST;
      sync2_q <= `FQ_PIN_RST;
      sync3_q <= `FQ_PIN_RST;
      pin_q <= `FQ_PIN_RST;
    end else if (i_ce) begin
      sync1_q <= {i_csn_pin, i_sck_pin, i_io_pin};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      pin_q <= pin_d;
    end
  end

  assign pin_d = (sync2_q == sync3_q) ? sync3_q : pin_q;
  assign sck_rise = i_ce & ~pin_q[4] & pin_d[4] & ~pin_q[5];
  assign sck_fall = i_ce & pin_q[4] & ~pin_d[4] & ~pin_q[5];
  assign cs_start = i_ce & pin_q[5] & ~pin_d[5];
  assign cs_end = i_ce & ~pin_q[5] & pin_d[5];

  // ----------------------------------------------------------------
  // Byte assembly
  // ----------------------------------------------------------------
  fsqmc_frame_t frame_q; // Phase of the current frame.
  fsqmc_run_t run_q; // Timed operation in progress.
  logic quad_q; // Quad command mode.
  logic [7:0] shift_q, shift_d; // Incoming bits, first bit in the high end.
  logic [3:0] cnt_q, cnt_d; // Bits of the current byte.
  logic [2:0] bytes_q; // Complete bytes in this frame, saturating.
  logic [7:0] opcode_q, data_q; // First and second byte.
  logic [23:0] addr_q; // Bytes two to four.
  logic byte_done;

  // In quad mode each edge carries a nibble, the high nibble first, so two edges make a byte.
  always_comb begin
    shift_d = quad_q ? {shift_q[3:0], pin_d[3:0]} : {shift_q[6:0], pin_d[0]};
    cnt_d = cnt_q + (quad_q ? 4'h4 : 4'h1);
    byte_done = sck_rise & (cnt_d == 4'h8) & ((frame_q == FR_CMD) | (frame_q == FR_ARG));
  end

  // Shifter, bit count and captured bytes.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      shift_q <= 8'h00;
      cnt_q <= 4'h0;
      bytes_q <= 3'h0;
      opcode_q <= 8'h00;
      data_q <= 8'h00;
      addr_q <= 24'h000000;
    end else if (cs_start) begin
      cnt_q <= 4'h0;
      bytes_q <= 3'h0;
    end else if (sck_rise) begin
      shift_q <= shift_d;
      cnt_q <= (cnt_d == 4'h8) ? 4'h0 : cnt_d;
      if (byte_done) begin
        bytes_q <= (bytes_q == 3'h7) ? bytes_q : bytes_q + 3'h1;
        if (bytes_q == 3'h0) begin
          opcode_q <= shift_d;
        end else begin
          addr_q <= {addr_q[15:0], shift_d};
        end
        if (bytes_q == 3'h1) begin
          data_q <= shift_d;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Instruction filter
  // ----------------------------------------------------------------
  logic erase_suspended_flag_q, program_suspended_flag_q, erase_held_q, wel_q, armed_q;
  logic [11:0] sus_cnt_q; // Suspend latency still to run.
  logic [23:0] erase_base_q, erase_mask_q;
  logic [15:0] page_q;
  logic [3:0] locks_q; // Row lock bits.
  logic [5:0] stat_q; // Status bits 7:2.
  logic busy, suspended;
  logic [7:0] func_val, stat_val;

  function automatic logic is_array_read(input logic [7:0] op);
    is_array_read = (op == `FQ_OP_READ) | (op == `FQ_OP_FAST) | (op == `FQ_OP_DUAL_IO) |
                    (op == `FQ_OP_DUAL_OUT) | (op == `FQ_OP_QUAD_IO) | (op == `FQ_OP_QUAD_OUT);
  endfunction

  // Instructions that may start while suspended; outside a suspend everything passes.
  function automatic logic cmd_ok(input logic [7:0] op, input logic es, input logic ps);
    logic any_sus, erase_only;
    any_sus = is_array_read(op) | (op == `FQ_OP_WR_EN) | (op == `FQ_OP_WR_DIS) |
              (op == `FQ_OP_WR_STAT) | (op == `FQ_OP_RD_STAT) | (op == `FQ_OP_RD_FUNC) |
              (op == `FQ_OP_RESUME_A) | (op == `FQ_OP_RESUME_B) | (op == `FQ_OP_ID_A) |
              (op == `FQ_OP_ID_B) | (op == `FQ_OP_ID_C) | (op == `FQ_OP_ID_D) | (op == `FQ_OP_UID) |
              (op == `FQ_OP_SFDP) | (op == `FQ_OP_NOP) | (op == `FQ_OP_RST_EN) | (op == `FQ_OP_RST) |
              (op == `FQ_OP_ROW_RD) | (op == `FQ_OP_QUAD_ON) | (op == `FQ_OP_QUAD_OFF) |
              (op == `FQ_OP_WRAP);
    erase_only = (op == `FQ_OP_PROG) | (op == `FQ_OP_PROG_Q_A) | (op == `FQ_OP_PROG_Q_B) |
                 (op == `FQ_OP_SUSP_A) | (op == `FQ_OP_SUSP_B) | (op == `FQ_OP_SEC_UNL) |
                 (op == `FQ_OP_SEC_LCK);
    cmd_ok = ~(es | ps) | any_sus | (erase_only & es & ~ps);
  endfunction

  assign suspended = erase_suspended_flag_q | program_suspended_flag_q;
  assign busy = (run_q != RUN_NONE) | (sus_cnt_q != 12'h000);
  assign func_val = {locks_q, erase_suspended_flag_q, program_suspended_flag_q, 2'b00};
  assign stat_val = {stat_q, wel_q, busy};

  logic op_taken, read_refused;
  logic [23:0] rd_addr;
  // Until the suspend latency ends only status polling gets through.
  assign op_taken = cmd_ok(shift_d, erase_suspended_flag_q, program_suspended_flag_q) & ((sus_cnt_q == 12'h000) | (shift_d == `FQ_OP_RD_STAT));
  assign rd_addr = {addr_q[15:0], shift_d};
  assign read_refused = (erase_suspended_flag_q & ((rd_addr & erase_mask_q) == erase_base_q)) |
                        (program_suspended_flag_q & (rd_addr[23:8] == page_q));

  // Frame phase: a refused opcode or read address parks the frame until chip select rises.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      frame_q <= FR_IDLE;
    end else if (cs_end) begin
      frame_q <= FR_IDLE;
    end else if (cs_start) begin
      frame_q <= FR_CMD;
    end else if (byte_done) begin
      unique case (frame_q)
        FR_CMD: begin
          if (!op_taken) begin
            frame_q <= FR_SKIP;
          end else if ((shift_d == `FQ_OP_RD_FUNC) || (shift_d == `FQ_OP_RD_STAT)) begin
            frame_q <= FR_OUT;
          end else begin
            frame_q <= FR_ARG;
          end
        end
        FR_ARG: begin
          if ((bytes_q == 3'h3) && is_array_read(opcode_q) && read_refused) begin
            frame_q <= FR_SKIP;
          end
        end
        default: begin
          frame_q <= frame_q;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Command decode at the end of a frame
  // ----------------------------------------------------------------
  logic exec, op_done, is_susp, is_res;
  logic do_prog, do_erase, do_susp, do_res, do_swrst, do_wrfun, do_wrstat;
  logic [7:0] op;

  // A command acts only when it ends on a byte boundary as chip select rises.
  always_comb begin
    op = opcode_q;
    exec = cs_end & (frame_q == FR_ARG) & (cnt_q == 4'h0);
    is_susp = (op == `FQ_OP_SUSP_A) | (op == `FQ_OP_SUSP_B);
    is_res = (op == `FQ_OP_RESUME_A) | (op == `FQ_OP_RESUME_B);
    do_prog = exec & wel_q & (bytes_q >= 3'h4) & (run_q == RUN_NONE) &
              ((op == `FQ_OP_PROG) | (op == `FQ_OP_PROG_Q_A) | (op == `FQ_OP_PROG_Q_B));
    do_erase = exec & wel_q & (bytes_q >= 3'h4) & (run_q == RUN_NONE) & ~erase_suspended_flag_q &
               ((op == `FQ_OP_SECT_A) | (op == `FQ_OP_SECT_B) | (op == `FQ_OP_BLK32) | (op == `FQ_OP_BLK64));
    do_susp = exec & is_susp & ((run_q == RUN_ERASE) | (run_q == RUN_PROG));
    do_res = exec & is_res & suspended;
    do_swrst = exec & (op == `FQ_OP_RST) & armed_q;
    do_wrfun = exec & (op == `FQ_OP_WR_FUNC) & wel_q & (bytes_q >= 3'h2);
    do_wrstat = exec & (op == `FQ_OP_WR_STAT) & (bytes_q >= 3'h2) & (wel_q | suspended);
    op_done = i_ce & i_wr & (i_addr == `FQ_REG_OPCTL) & i_wdata[`FQ_OPCTL_DONE] & (run_q != RUN_NONE);
  end

  // Reset enable arms only the next frame that carries at least one whole byte.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      armed_q <= 1'b0;
    end else if (cs_end && (bytes_q != 3'h0)) begin
      armed_q <= exec & (op == `FQ_OP_RST_EN);
    end
  end

  // Quad mode: entry from serial form, exit only from a full quad-format byte.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      quad_q <= 1'b0;
    end else if (exec && (op == `FQ_OP_QUAD_ON)) begin
      quad_q <= 1'b1;
    end else if (exec && (op == `FQ_OP_QUAD_OFF) && quad_q) begin
      quad_q <= 1'b0;
    end
  end

  // Row locks are one-time: bits are only ever ORed in.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      locks_q <= 4'h0;
    end else if (do_wrfun) begin
      locks_q <= locks_q | data_q[7:4];
    end
  end

  // Volatile status bits written by the status write.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      stat_q <= `FQ_STAT_RST;
    end else if (do_wrstat) begin
      stat_q <= data_q[7:2];
    end
  end

  // Write enable latch; a set in the same cycle as a clear wins.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      wel_q <= 1'b0;
    end else if (exec && (op == `FQ_OP_WR_EN)) begin
      wel_q <= 1'b1;
    end else if (do_susp || do_swrst || do_wrfun || op_done || (exec && (op == `FQ_OP_WR_DIS))) begin
      wel_q <= 1'b0;
    end else if (do_wrstat && !suspended) begin
      wel_q <= 1'b0;
    end
  end

  // Suspend latency: the device stays busy and deaf to all but status reads for the suspend time.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      sus_cnt_q <= 12'h000;
    end else if (do_susp) begin
      sus_cnt_q <= 12'(`FQ_TSUS_CYC);
    end else if (do_swrst) begin
      sus_cnt_q <= 12'h000;
    end else if (i_ce && (sus_cnt_q != 12'h000)) begin
      sus_cnt_q <= sus_cnt_q - 12'h001;
    end
  end

  // Running operation, suspend flags and the region each protects.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      run_q <= RUN_NONE;
      erase_suspended_flag_q <= 1'b0;
      program_suspended_flag_q <= 1'b0;
      erase_held_q <= 1'b0;
      erase_base_q <= 24'h000000;
      erase_mask_q <= `FQ_MASK_SECT;
      page_q <= 16'h0000;
    end else if (do_swrst) begin
      run_q <= RUN_NONE;
      erase_suspended_flag_q <= 1'b0;
      program_suspended_flag_q <= 1'b0;
      erase_held_q <= 1'b0;
    end else if (do_susp) begin
      run_q <= RUN_NONE;
      if (run_q == RUN_ERASE) begin
        erase_suspended_flag_q <= 1'b1;
        erase_held_q <= 1'b1;
      end else begin
        program_suspended_flag_q <= 1'b1;
      end
    end else if (do_res) begin
      erase_suspended_flag_q <= 1'b0;
      program_suspended_flag_q <= 1'b0;
      if (program_suspended_flag_q) begin
        run_q <= RUN_PROG;
      end else begin
        run_q <= RUN_ERASE;
        erase_held_q <= 1'b0;
      end
    end else if (do_prog) begin
      run_q <= RUN_PROG;
      page_q <= addr_q[23:8];
    end else if (do_erase) begin
      run_q <= RUN_ERASE;
      erase_mask_q <= (op == `FQ_OP_BLK64) ? `FQ_MASK_B64 : (op == `FQ_OP_BLK32) ? `FQ_MASK_B32 : `FQ_MASK_SECT;
      erase_base_q <= addr_q & ((op == `FQ_OP_BLK64) ? `FQ_MASK_B64 :
                                (op == `FQ_OP_BLK32) ? `FQ_MASK_B32 : `FQ_MASK_SECT);
    end else if (exec && wel_q && (run_q == RUN_NONE) && !suspended &&
                 ((op == `FQ_OP_CHIP_A) || (op == `FQ_OP_CHIP_B))) begin
      run_q <= RUN_CHIP;
    end else if (op_done) begin
      // A program finished inside an erase suspend leaves the erase held; a resumed one picks it up.
      if (erase_held_q && !erase_suspended_flag_q) begin
        run_q <= RUN_ERASE;
        erase_held_q <= 1'b0;
      end else begin
        run_q <= RUN_NONE;
      end
    end
  end

  // ----------------------------------------------------------------
  // Link output
  // ----------------------------------------------------------------
  logic [7:0] out_sh_q; // Register byte being rotated out; it repeats while clocks continue.

  // Register reads load on the opcode's last edge and shift on falling edges.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      out_sh_q <= 8'h00;
      o_io_out <= 4'h0;
      o_io_oe <= 4'h0;
    end else if (cs_end || cs_start) begin
      o_io_oe <= 4'h0;
    end else if (byte_done && (frame_q == FR_CMD)) begin
      out_sh_q <= (shift_d == `FQ_OP_RD_FUNC) ? func_val : stat_val;
    end else if (sck_fall && (frame_q == FR_OUT)) begin
      if (quad_q) begin
        o_io_out <= out_sh_q[7:4];
        o_io_oe <= 4'hF;
        out_sh_q <= {out_sh_q[3:0], out_sh_q[7:4]};
      end else begin
        o_io_out <= {2'b00, out_sh_q[7], 1'b0};
        o_io_oe <= 4'h2;
        out_sh_q <= {out_sh_q[6:0], out_sh_q[7]};
      end
    end
  end

  // Array read permission for the outside data path.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_read_grant <= 1'b0;
    end else if (cs_end || cs_start) begin
      o_read_grant <= 1'b0;
    end else if (byte_done && (frame_q == FR_ARG) && (bytes_q == 3'h3) && is_array_read(opcode_q)) begin
      o_read_grant <= ~read_refused;
    end
  end

  // ----------------------------------------------------------------
  // Register port and status outputs
  // ----------------------------------------------------------------
  // Read data stand only in the cycle after the strobe; unmapped offsets read zero.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 32'h00000000;
      o_quad_mode <= 1'b0;
      o_write_in_progress <= 1'b0;
    end else if (i_ce) begin
      o_quad_mode <= quad_q;
      o_write_in_progress <= busy;
      o_rdata <= 32'h00000000;
      if (i_rd && (i_addr == `FQ_REG_STAT)) begin
        o_rdata <= {22'h000000, erase_held_q, quad_q, stat_val};
      end else if (i_rd && (i_addr == `FQ_REG_OPCTL)) begin
        o_rdata <= {28'h0000000, run_q};
      end else if (i_rd && (i_addr == `FQ_REG_FUNC)) begin
        o_rdata <= {24'h000000, func_val};
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence erase_susp_s;
    do_susp && (run_q == RUN_ERASE);
  endsequence
  sequence latency_hold_s;
    (sus_cnt_q != 12'h000)[*8];
  endsequence

  lock_stays_set_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (($past(locks_q) & ~locks_q) == 4'h0)) else $error("row lock bit cleared");
  susp_clears_latch_a: assert property (@(posedge i_clock) disable iff (i_rst)
    ($rose(erase_suspended_flag_q) || $rose(program_suspended_flag_q)) |-> !wel_q) else $error("latch set after suspend");
  erase_latency_a: assert property (@(posedge i_clock) disable iff (i_rst)
    erase_susp_s |=> erase_suspended_flag_q && busy ##0 latency_hold_s) else $error("erase suspend not busy");
  chip_no_susp_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (exec && is_susp && (run_q == RUN_CHIP) && !op_done) |=> (run_q == RUN_CHIP) && !erase_suspended_flag_q)
    else $error("chip erase suspended");
  resume_clears_a: assert property (@(posedge i_clock) disable iff (i_rst)
    do_res |=> !erase_suspended_flag_q && !program_suspended_flag_q && (run_q != RUN_NONE)) else $error("resume left flags");
  quad_exit_a: assert property (@(posedge i_clock) disable iff (i_rst)
    $fell(quad_q) |-> $past(exec) && ($past(opcode_q) == `FQ_OP_QUAD_OFF)) else $error("quad left wrongly");
  quad_entry_a: assert property (@(posedge i_clock) disable iff (i_rst)
    $rose(quad_q) |-> ($past(opcode_q) == `FQ_OP_QUAD_ON)) else $error("quad entered wrongly");
  filter_hold_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (byte_done && (frame_q == FR_CMD) && suspended && !cmd_ok(shift_d, erase_suspended_flag_q, program_suspended_flag_q)) |=>
    (frame_q == FR_SKIP) && $stable(erase_suspended_flag_q) && $stable(program_suspended_flag_q)) else $error("refused opcode acted");
  func_latch_a: assert property (@(posedge i_clock) disable iff (i_rst)
    do_wrfun |=> !wel_q ##1 !wel_q || $past(exec)) else $error("latch kept after function write");
  reset_gate_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (exec && (op == `FQ_OP_RST) && !armed_q && suspended) |=> suspended) else $error("reset not gated");
  func_read_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (byte_done && (frame_q == FR_CMD) && op_taken && (shift_d == `FQ_OP_RD_FUNC)) |=>
    (out_sh_q == $past(func_val)) && (frame_q == FR_OUT)) else $error("function read not loaded");
endmodule

// File: tb/fsqmc_host.sv
// Purpose: Host model of the flash link: select, clock and data pins.
// Assumes: Clock mode 0, link clock period is eight system clocks.
// Notes: Link clock stands low between frames; released data shows the inverse of the last value.
`timescale 1ns/1ps
module fsqmc_host (
  // System side
  input wire logic i_clock,
  input wire logic [3:0] i_io_wire,
  input wire logic i_grant,
  // Link pins
  output logic o_csn,
  output logic o_sck,
  output logic [3:0] o_io
);
  // Idle pins before the first frame.
  initial begin
    o_csn = 1'b1;
    o_sck = 1'b0;
    o_io = 4'h0;
  end
  // One frame of nb bytes from the top of d; returns the last byte heard and the grant.
  task automatic xfer(input logic [39:0] d, input int nb, input logic q, output logic [7:0] rx, output logic g);
    int n;
    n = q ? nb * 2 : nb * 8;
    o_csn <= 1'b0;
    repeat (4) @(posedge i_clock);
    for (int i = 0; i < n; i++) begin
      o_sck <= 1'b0;
      o_io <= q ? d[39 - 4 * i -: 4] : {3'h0, d[39 - i]};
      repeat (4) @(posedge i_clock);
      o_sck <= 1'b1;
      repeat (4) @(posedge i_clock);
      rx = q ? {rx[3:0], i_io_wire} : {rx[6:0], i_io_wire[1]};
      g = i_grant;
    end
    o_sck <= 1'b0;
    repeat (4) @(posedge i_clock);
    o_csn <= 1'b1;
    o_io <= ~o_io;
    repeat (8) @(posedge i_clock);
  endtask
endmodule

// File: tb/tb_flash_suspend_quad_mode_ctrl.sv
// Purpose: Self-checking bench of the flash command block.
// Assumes: Host model drives the link; registers are read over the plain port.
// Notes: The suspend latency is a fixed count, so the run waits it out.
`timescale 1ns/1ps
module tb_flash_suspend_quad_mode_ctrl;
  logic i_clock, i_rst, i_wr, i_rd, csn, sck, g, grant, quad, write_in_progress;
  logic rd_d = 1'b0; // Read strobe seen one cycle ago; only the checking process drives it.
  logic [3:0] i_addr, pin, io_out, io_oe, io_w;
  logic [31:0] i_wdata, o_rdata;
  logic [7:0] rx, r1, r2;
  logic [3:0] lk;
  int fails, total_checks;
  logic [31:0] exp_q[$], msk_q[$];
  assign io_w = (io_oe & io_out) | (~io_oe & pin);
  fsqmc_top dut_u (.i_clock(i_clock), .i_rst(i_rst), .i_ce(1'b1), .i_csn_pin(csn), .i_sck_pin(sck),
    .i_io_pin(io_w), .o_io_out(io_out), .o_io_oe(io_oe), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .o_quad_mode(quad), .o_write_in_progress(write_in_progress), .o_read_grant(grant));
  fsqmc_host host_u (.i_clock(i_clock), .i_io_wire(io_w), .i_grant(grant), .o_csn(csn), .o_sck(sck), .o_io(pin));
  initial begin
    i_clock = 1'b0;
    forever #20 i_clock = ~i_clock;
  end
  // Compare and count; a mismatch is reported at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Register read; the expected value and mask wait in the queue.
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    i_rd <= 1'b1;
    i_addr <= a;
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(posedge i_clock);
    i_rd <= 1'b0;
    @(posedge i_clock);
  endtask
  // Read data stand only in the cycle after the strobe, so they are taken there.
  always @(posedge i_clock) begin
    if (rd_d) chk(o_rdata & msk_q.pop_front(), exp_q.pop_front());
    rd_d <= i_rd;
  end
  // Right-justified frame handed to the host model.
  task automatic f(input logic [39:0] d, input int nb, input logic q);
    host_u.xfer(d << (8 * (5 - nb)), nb, q, rx, g);
  endtask
  task automatic results;
    $display("checks=%0d fails=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Busy must drop within a bound, else the run is cut short.
  task automatic wait_idle;
    int n;
    n = 0;
    while (write_in_progress !== 1'b0 && n < 3000) begin
      @(posedge i_clock);
      n++;
    end
    if (n == 3000) begin
      fails++;
      results();
    end
  endtask
  initial begin
    {i_rst, i_wr, i_rd, i_addr, i_wdata, fails, total_checks} = '0;
    i_rst = 1'b1;
    r1 = 8'($urandom(52));
    r2 = 8'($urandom);
    lk = r1[7:4] | r2[7:4];
    repeat (10) @(posedge i_clock);
    i_rst <= 1'b0;
    @(posedge i_clock);
    rd(4'h8, 32'h0, '1);
    rd(4'hC, 32'h0, '1);
    f({8'h42, r1}, 2, 0);
    rd(4'h8, 32'h0, '1);
    f(40'h06, 1, 0);
    f({8'h42, r1}, 2, 0);
    rd(4'h0, 32'h0, 32'h2);
    f(40'h06, 1, 0);
    f({8'h42, r2}, 2, 0);
    rd(4'h8, {24'h0, lk, 4'h0}, 32'hFF);
    f(40'h4800, 2, 0);
    chk(rx, {lk, 4'h0});
    f(40'h06, 1, 0);
    f(40'h2001_2345, 4, 0);
    rd(4'h4, 32'h4, 32'hF);
    rd(4'h0, 32'h1, 32'h1);
    f(40'h06, 1, 0);
    f(40'h75, 1, 0);
    f(40'h06, 1, 0);
    rd(4'h0, 32'h1, 32'h3);
    rd(4'h8, {24'h0, lk, 4'h8}, 32'hFF);
    wait_idle();
    f(40'h0305_0000_00, 5, 0);
    chk(g, 1);
    f(40'h0301_2000_00, 5, 0);
    chk(g, 0);
    // An erase opcode while erase is suspended is refused and must leave the latch as it was.
    f(40'h06, 1, 0);
    f(40'h2005_0000, 4, 0);
    rd(4'h0, 32'h2, 32'h3);
    rd(4'h4, 32'h1, 32'hF);
    f(40'h35, 1, 0);
    chk(quad, 1);
    f(40'h4800, 2, 1);
    chk(rx, {lk, 4'h8});
    f(40'h7A, 1, 1);
    rd(4'h8, {24'h0, lk, 4'h0}, 32'hFF);
    f(40'hF5, 1, 0);
    chk(quad, 1);
    f(40'hF5, 1, 1);
    chk(quad, 0);
    i_wr <= 1'b1;
    i_addr <= 4'h4;
    i_wdata <= 32'h1;
    @(posedge i_clock);
    i_wr <= 1'b0;
    repeat (3) @(posedge i_clock);
    rd(4'h0, 32'h0, 32'h1);
    // A suspend during a whole-chip erase is ignored.
    f(40'h06, 1, 0);
    f(40'hC7, 1, 0);
    f(40'h75, 1, 0);
    rd(4'h4, 32'h8, 32'hF);
    rd(4'h8, {24'h0, lk, 4'h0}, 32'hFF);
    chk(write_in_progress, 1);
    // Let the last queued read be compared before the run ends.
    repeat (2) @(posedge i_clock);
    results();
  end
endmodule
